/* File: hw/dcsfr_pkg.sv */
// package: register map, field layout, reset values and types of the channel select block
package dcsfr_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [4:0]  ADDR_CHANNEL_SELECT   = 5'h00;
    localparam logic [4:0]  ADDR_FUNCTION_ONE     = 5'h01;
    localparam logic [4:0]  ADDR_FUNCTION_TWO     = 5'h02;
    localparam logic [4:0]  ADDR_CHAN_FIRST       = 5'h03;
    localparam logic [4:0]  ADDR_CHAN_LAST        = 5'h18;
    localparam int          CHAN_REG_COUNT        = 22;
    localparam int          CHAN_REG_WIDTH        = 32;
    localparam logic [2:0]  BYTES_CHANNEL_SELECT  = 3'h1;
    localparam logic [2:0]  BYTES_FUNCTION_ONE    = 3'h3;
    localparam logic [2:0]  BYTES_FUNCTION_TWO    = 3'h2;
    localparam logic [2:0]  BYTES_CHAN            = 3'h4;

    // ************************************************************
    // reset values and writable masks
    // ************************************************************
    localparam logic [7:0]  CHANNEL_SELECT_RESET  = 8'hc0;
    localparam logic [7:0]  CHANNEL_SELECT_MASK   = 8'hc7;
    localparam logic [23:0] FUNCTION_ONE_RESET    = 24'h000000;
    localparam logic [23:0] FUNCTION_ONE_MASK     = 24'hff7f80;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CS_CHAN_EN_LSB   = 6;
    localparam int CS_MODE_LSB      = 1;
    localparam int CS_LSB_FIRST_BIT = 0;
    localparam int F1_VCO_HIGH_BIT  = 23;
    localparam int F1_PLL_LSB       = 18;
    localparam int F1_CP_LSB        = 16;
    localparam int F1_PIN_LSB       = 12;
    localparam int F1_RAMP_LSB      = 10;
    localparam int F1_LEVEL_LSB     = 8;
    localparam int F1_REF_PD_BIT    = 7;
    localparam logic [4:0] PLL_FACTOR_MIN = 5'h04;
    localparam logic [4:0] PLL_FACTOR_MAX = 5'h14;

    // ************************************************************
    // serial framing
    // ************************************************************
    localparam int          INSTR_BITS   = 8;
    localparam int          INSTR_RD_BIT = 7;
    localparam logic [1:0]  CHAN_EN_CH1  = 2'h2;
    localparam logic [1:0]  CHAN_EN_CH0  = 2'h1;
    localparam logic [1:0]  CHAN_EN_BOTH = 2'h3;

    typedef enum logic [1:0] {
        MODE_TWO_WIRE   = 2'h0,
        MODE_THREE_WIRE = 2'h1,
        MODE_TWO_BIT    = 2'h2,
        MODE_FOUR_BIT   = 2'h3
    } dcsfr_mode_t;

    typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_DONE} dcsfr_phase_t;

    typedef struct packed {
        logic [1:0]  chan_en;
        dcsfr_mode_t mode;
        logic        lsb_first;
    } dcsfr_port_cfg_t;

    typedef struct packed {
        logic       vco_high;
        logic       pll_enable;
        logic [4:0] pll_factor;
        logic [1:0] cp_code;
        logic [2:0] pin_setup;
        logic [1:0] amp_ramp_time;
        logic [1:0] mod_levels;
        logic       ref_pd;
    } dcsfr_func_t;

endpackage

/* File: hw/dcsfr_chan_mem.sv */
// per-channel copies of the channel and profile registers
module dcsfr_chan_mem
    import dcsfr_pkg::*;
#(
    parameter int DEPTH = CHAN_REG_COUNT,
    parameter int WIDTH = CHAN_REG_WIDTH
) (
    input  wire logic                     i_clock,
    input  wire logic [1:0]               i_we,
    input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input  wire logic [WIDTH-1:0]         i_wdata,
    input  wire logic                     i_rd_en,
    input  wire logic                     i_rd_bank,
    input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic      [WIDTH-1:0]         o_rdata
);
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
        $error("dcsfr_chan_mem: bad size");
    end

    // ************************************************************
    // one array per channel, written only where enabled
    // ************************************************************
    for (genvar b = 0; b < 2; b++) begin : g_bank
        logic [WIDTH-1:0] mem [DEPTH];
        always_ff @(posedge i_clock) begin
            if (i_we[b]) begin
                mem[i_waddr] <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rd_en) begin
            o_rdata <= i_rd_bank ? g_bank[1].mem[i_raddr] : g_bank[0].mem[i_raddr];
        end
    end

endmodule

/* File: hw/dcsfr_regs.sv */
// serial port and control registers of the two-channel synthesizer
module dcsfr_regs
    import dcsfr_pkg::*;
(
    input  wire logic            i_clock,
    input  wire logic            i_sys_rst,
    input  wire logic            i_cs_n,
    input  wire logic            i_sclk,
    input  wire logic [3:0]      i_sdio,
    input  wire logic            i_io_update,
    output logic                 o_sdio0_out,
    output logic                 o_sdio0_oe_n,
    output logic                 o_sdo,
    output dcsfr_port_cfg_t      o_port_cfg,
    output dcsfr_func_t          o_func
);
    localparam int AW = $clog2(CHAN_REG_COUNT);

    logic         sclk_q;
    logic         edge_rise;
    dcsfr_phase_t phase;
    logic [5:0]   cnt;
    logic [31:0]  sr;
    logic [31:0]  next_sr;
    logic [5:0]   k;
    logic [5:0]   target;
    logic         last;
    logic         reading;
    logic [4:0]   addr;
    logic [7:0]   next_instr;
    logic [5:0]   nbits;
    logic [31:0]  word;
    logic         wr_fire;
    logic         instr_fire;
    logic         rd_load;
    logic [31:0]  rd_word;
    logic [31:0]  out_sr;
    logic [7:0]   channel_select;
    logic [23:0]  func_shadow;
    logic [23:0]  func_active;
    logic [31:0]  mem_rdata;
    logic         chan_hit;
    logic [AW-1:0] chan_idx;
    logic [1:0]   mem_we;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic [2:0] reg_bytes(input logic [4:0] a);
        unique case (a)
            ADDR_CHANNEL_SELECT: reg_bytes = BYTES_CHANNEL_SELECT;
            ADDR_FUNCTION_ONE:   reg_bytes = BYTES_FUNCTION_ONE;
            ADDR_FUNCTION_TWO:   reg_bytes = BYTES_FUNCTION_TWO;
            default:             reg_bytes = BYTES_CHAN;
        endcase
    endfunction

    function automatic logic in_chan(input logic [4:0] a);
        in_chan = (a >= ADDR_CHAN_FIRST) && (a <= ADDR_CHAN_LAST);
    endfunction

    // ************************************************************
    // serial shifter
    // ************************************************************
    always_comb begin
        unique case (dcsfr_mode_t'(channel_select[CS_MODE_LSB +: 2]))
            MODE_TWO_WIRE, MODE_THREE_WIRE: k = 6'h01;
            MODE_TWO_BIT:                   k = 6'h02;
            MODE_FOUR_BIT:                  k = 6'h04;
        endcase
    end

    always_comb begin
        next_sr = sr;
        unique case (k)
            6'h02: next_sr = channel_select[CS_LSB_FIRST_BIT] ?
                       {i_sdio[1:0], sr[31:2]} : {sr[29:0], i_sdio[1:0]};
            6'h04: next_sr = channel_select[CS_LSB_FIRST_BIT] ?
                       {i_sdio[3:0], sr[31:4]} : {sr[27:0], i_sdio[3:0]};
            default: next_sr = channel_select[CS_LSB_FIRST_BIT] ?
                       {i_sdio[0], sr[31:1]} : {sr[30:0], i_sdio[0]};
        endcase
    end

    assign edge_rise  = i_sclk && !sclk_q && !i_cs_n;
    assign nbits      = {reg_bytes(addr), 3'h0};
    assign target     = (phase == PH_INSTR) ? 6'(INSTR_BITS) : nbits;
    assign last       = (6'(cnt + k) == target);
    assign next_instr = channel_select[CS_LSB_FIRST_BIT] ? next_sr[31:24] : next_sr[7:0];
    assign word       = channel_select[CS_LSB_FIRST_BIT] ?
                        (next_sr >> (6'd32 - nbits)) : next_sr;
    assign instr_fire = edge_rise && (phase == PH_INSTR) && last;
    assign wr_fire    = edge_rise && (phase == PH_DATA) && last && !reading;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= i_sclk;
        end
    end

    // cs high aborts any partial frame, so a glitch never half-writes a register
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase   <= PH_INSTR;
            cnt     <= 6'h00;
            sr      <= 32'h0;
            reading <= 1'b0;
            addr    <= 5'h00;
        end else if (i_cs_n) begin
            phase <= PH_INSTR;
            cnt   <= 6'h00;
            sr    <= 32'h0;
        end else if (edge_rise && phase != PH_DONE) begin
            if (last) begin
                cnt   <= 6'h00;
                sr    <= 32'h0;
                phase <= (phase == PH_INSTR) ? PH_DATA : PH_DONE;
                if (phase == PH_INSTR) begin
                    reading <= next_instr[INSTR_RD_BIT];
                    addr    <= next_instr[4:0];
                end
            end else begin
                cnt <= 6'(cnt + k);
                sr  <= next_sr;
            end
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            channel_select <= CHANNEL_SELECT_RESET;
        end else if (wr_fire && addr == ADDR_CHANNEL_SELECT) begin
            channel_select <= word[7:0] & CHANNEL_SELECT_MASK;
        end
    end

    // function register waits in a shadow until the update strobe
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            func_shadow <= FUNCTION_ONE_RESET;
            func_active <= FUNCTION_ONE_RESET;
        end else begin
            if (wr_fire && addr == ADDR_FUNCTION_ONE) begin
                func_shadow <= word[23:0] & FUNCTION_ONE_MASK;
            end
            if (i_io_update) begin
                func_active <= func_shadow;
            end
        end
    end

    assign chan_hit = in_chan(addr);
    assign chan_idx = AW'(addr - ADDR_CHAN_FIRST);
    assign mem_we   = (wr_fire && chan_hit) ?
                      channel_select[CS_CHAN_EN_LSB +: 2] : 2'h0;

    dcsfr_chan_mem #(
        .DEPTH (CHAN_REG_COUNT),
        .WIDTH (CHAN_REG_WIDTH)
    ) u_mem (
        .i_clock   (i_clock),
        .i_we      (mem_we),
        .i_waddr   (chan_idx),
        .i_wdata   (word),
        .i_rd_en   (instr_fire),
        .i_rd_bank (!channel_select[CS_CHAN_EN_LSB]),
        .i_raddr   (AW'(next_instr[4:0] - ADDR_CHAN_FIRST)),
        .o_rdata   (mem_rdata)
    );

    // ************************************************************
    // read path, single-bit modes only
    // ************************************************************
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rd_load <= 1'b0;
        end else begin
            rd_load <= instr_fire && next_instr[INSTR_RD_BIT];
        end
    end

    always_comb begin
        unique case (addr)
            ADDR_CHANNEL_SELECT: rd_word = {24'h0, channel_select};
            ADDR_FUNCTION_ONE:   rd_word = {8'h0, func_shadow};
            default:             rd_word = chan_hit ? mem_rdata : 32'h0;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            out_sr <= 32'h0;
        end else if (rd_load) begin
            out_sr <= channel_select[CS_LSB_FIRST_BIT] ?
                      rd_word : (rd_word << (6'd32 - nbits));
        end else if (edge_rise && phase == PH_DATA && reading) begin
            out_sr <= channel_select[CS_LSB_FIRST_BIT] ? (out_sr >> 1) : (out_sr << 1);
        end
    end

    always_comb begin
        o_sdio0_out  = channel_select[CS_LSB_FIRST_BIT] ? out_sr[0] : out_sr[31];
        o_sdio0_oe_n = !(reading && phase == PH_DATA && !i_cs_n &&
                       channel_select[CS_MODE_LSB +: 2] == MODE_TWO_WIRE);
        o_sdo        = (channel_select[CS_MODE_LSB +: 2] == MODE_THREE_WIRE) ?
                       o_sdio0_out : 1'b0;
    end

    // ************************************************************
    // decoded outputs
    // ************************************************************
    always_comb begin
        o_port_cfg.chan_en   = channel_select[CS_CHAN_EN_LSB +: 2];
        o_port_cfg.mode      = dcsfr_mode_t'(channel_select[CS_MODE_LSB +: 2]);
        o_port_cfg.lsb_first = channel_select[CS_LSB_FIRST_BIT];
        o_func.vco_high      = func_active[F1_VCO_HIGH_BIT];
        o_func.pll_factor    = func_active[F1_PLL_LSB +: 5];
        o_func.pll_enable    = (func_active[F1_PLL_LSB +: 5] >= PLL_FACTOR_MIN) &&
                               (func_active[F1_PLL_LSB +: 5] <= PLL_FACTOR_MAX);
        o_func.cp_code       = func_active[F1_CP_LSB +: 2];
        o_func.pin_setup     = func_active[F1_PIN_LSB +: 3];
        o_func.amp_ramp_time = func_active[F1_RAMP_LSB +: 2];
        o_func.mod_levels    = func_active[F1_LEVEL_LSB +: 2];
        o_func.ref_pd        = func_active[F1_REF_PD_BIT];
    end

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_chan_sel_write;
        wr_fire && addr == ADDR_CHANNEL_SELECT;
    endsequence

    AST_CHAN_SEL_IMMEDIATE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        s_chan_sel_write |=> o_port_cfg.chan_en == $past(word[7:6]))
        else $error("channel enables did not apply at once");
    AST_ROUTE_CH1: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (wr_fire && chan_hit && o_port_cfg.chan_en == CHAN_EN_CH1) |-> mem_we == 2'h2)
        else $error("enable code 10 did not route to channel 1 only");
    AST_ROUTE_COPY: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (mem_we != 2'h0) |-> (wr_fire && chan_hit && mem_we == o_port_cfg.chan_en))
        else $error("channel copy written without matching enable");
    AST_RESET_BOTH: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $fell(i_sys_rst) |-> o_port_cfg.chan_en == CHAN_EN_BOTH)
        else $error("channels not both enabled after reset");
    AST_FOUR_BIT_STEP: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (edge_rise && phase != PH_DONE && !last && o_port_cfg.mode == MODE_FOUR_BIT)
        |=> cnt == 6'($past(cnt) + 4))
        else $error("four-bit mode did not take four bits per edge");
    AST_LSB_LOAD: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (rd_load && o_port_cfg.lsb_first) |=> out_sr == $past(rd_word))
        else $error("lsb first read not loaded unshifted");
    AST_FUNC_HELD: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !$stable(func_active) |-> $past(i_io_update))
        else $error("function register changed without update");
    AST_PLL_RANGE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_func.pll_enable |-> (o_func.pll_factor inside {[4:20]}))
        else $error("multiplier enabled out of range");
    AST_UNUSED_ZERO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        channel_select[5:3] == 3'h0 && func_shadow[15] == 1'b0)
        else $error("unused bit stored as one");

endmodule

/* File: tb/dcsfr_host_model.sv */
// host model that drives serial frames into the register block
module dcsfr_host_model
    import dcsfr_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rd_line,
    output logic            o_cs_n,
    output logic            o_sclk,
    output logic [3:0]      o_sdio
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // frame driver
    // ********
    // sclk stands low between frames; each level is held for several clocks
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdio = 4'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic shift(input logic [31:0] v, input int n, input int k, input logic lsb,
                         input logic rdm, inout logic [31:0] r);
        int i;
        for (int j = 0; j < n / k; j++) begin
            i = lsb ? j * k : n - k - j * k;
            // a released line keeps changing, so a stale bit cannot pass
            o_sdio = rdm ? ~o_sdio : 4'((v >> i) & ((32'h1 << k) - 1));
            tick(3);
            if (rdm) begin
                r[i] = i_rd_line;
            end
            o_sclk = 1'b1;
            tick(2);
            o_sclk = 1'b0;
        end
    endtask

    task automatic frame(input logic [7:0] ins, input logic [31:0] wd, input int nb,
                         input int k, input logic lsb, output logic [31:0] rd);
        rd = 32'h0;
        o_cs_n = 1'b0;
        tick(1);
        shift(32'(ins), 8, k, lsb, 1'b0, rd);
        shift(wd, nb, k, lsb, ins[7], rd);
        o_cs_n = 1'b1;
        o_sdio = ~o_sdio;
        tick(2);
    endtask
endmodule

/* File: tb/test_dcsfr_regs.sv */
// self-checking bench of the channel select and first function registers
module test_dcsfr_regs
    import dcsfr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // bench signals
    // ********
    logic            clock = 1'b0;
    logic            sys_rst = 1'b1;
    logic            io_update = 1'b0;
    logic            cs_n;
    logic            sclk;
    logic [3:0]      host_sdio;
    logic [3:0]      sdio_wire;
    logic            sdio0_out;
    logic            sdio0_oe_n;
    logic            sdo;
    logic            rd_sel3 = 1'b0;
    logic            lsb_cur = 1'b0;
    int              k_cur = 1;
    int              num_errors = 0;
    int              n_tests = 0;
    integer          seed = 32'h999c;
    dcsfr_port_cfg_t port_cfg;
    dcsfr_func_t     func;
    logic [31:0]     r;
    logic [23:0]     v;
    logic [4:0]      corner [4] = '{5'h03, 5'h04, 5'h14, 5'h15};

    always #20 clock = ~clock;

    // the device owns sdio0 only while its enable is low
    assign sdio_wire = {host_sdio[3:1], sdio0_oe_n ? host_sdio[0] : sdio0_out};

    dcsfr_regs uut (
        .i_clock     (clock),
        .i_sys_rst   (sys_rst),
        .i_cs_n      (cs_n),
        .i_sclk      (sclk),
        .i_sdio      (sdio_wire),
        .i_io_update (io_update),
        .o_sdio0_out (sdio0_out),
        .o_sdio0_oe_n(sdio0_oe_n),
        .o_sdo       (sdo),
        .o_port_cfg  (port_cfg),
        .o_func      (func)
    );

    dcsfr_host_model host (
        .i_clock  (clock),
        .i_rd_line(rd_sel3 ? sdo : sdio_wire[0]),
        .o_cs_n   (cs_n),
        .o_sclk   (sclk),
        .o_sdio   (host_sdio)
    );
    // ********
    // tasks
    // ********
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic dcsfr_func_t exp_func(input logic [23:0] fv);
        return '{fv[23], fv[22:18] >= 5'h04 && fv[22:18] <= 5'h14, fv[22:18], fv[17:16],
                 fv[14:12], fv[11:10], fv[9:8], fv[7]};
    endfunction

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input int nb);
        host.frame({3'h0, a}, d, nb, k_cur, lsb_cur, r);
    endtask

    // reads are only issued in the single-bit modes
    task automatic rd(input logic [4:0] a, input int nb);
        host.frame({3'h4, a}, 32'h0, nb, 1, lsb_cur, r);
    endtask

    // the bench follows the port format that the register now selects
    task automatic wcs(input logic [7:0] c);
        wr(5'h00, {24'h0, c}, 8);
        check("port_cfg", 32'(port_cfg), {27'h0, c[7:6], c[2:1], c[0]});
        k_cur = c[2] ? (c[1] ? 4 : 2) : 1;
        lsb_cur = c[0];
        rd_sel3 = (c[2:1] == 2'h1);
    endtask

    task automatic func_case(input logic [23:0] fv);
        dcsfr_func_t held;
        held = func;
        wr(5'h01, {8'h0, fv}, 24);
        check("func_held", 32'(func), 32'(held));
        @(posedge clock);
        #1 io_update = 1'b1;
        @(posedge clock);
        #1 io_update = 1'b0;
        check("func_out", 32'(func), 32'(exp_func(fv)));
    endtask
    // ********
    // scenarios
    // ********
    initial begin
        repeat (5) @(posedge clock);
        #1 sys_rst = 1'b0;
        host.tick(1);
        check("rst_cfg", 32'(port_cfg), 32'h18);
        check("rst_func", 32'(func), 32'h0);
        rd(5'h00, 8);
        check("rst_cs", r, 32'hc0);
        wcs(8'h40);
        wr(5'h04, 32'h1111aaaa, 32);
        wcs(8'h80);
        wr(5'h04, 32'h2222bbbb, 32);
        rd(5'h04, 32);
        check("ch1_copy", r, 32'h2222bbbb);
        wcs(8'h40);
        rd(5'h04, 32);
        check("ch0_copy", r, 32'h1111aaaa);
        wcs(8'hc0);
        wr(5'h18, 32'h3333cccc, 32);
        rd(5'h18, 32);
        check("both_ch0", r, 32'h3333cccc);
        wcs(8'h80);
        rd(5'h18, 32);
        check("both_ch1", r, 32'h3333cccc);
        wr(5'h02, 32'h0000ffff, 16);
        rd(5'h02, 16);
        check("unmapped", r, 32'h0);
        for (int i = 0; i < 12; i++) begin
            v = 24'($random(seed)) & 24'hff7f80;
            if (i < 4) begin
                v[22:18] = corner[i];
            end
            func_case(v);
            rd(5'h01, 24);
            check("func_rd", r, {8'h0, v});
        end
        // reserved bits written as ones, a refusal case
        func_case(24'hffffff);
        rd(5'h01, 24);
        check("func_rsv", r, 32'hff7f80);
        wcs(8'hfa);
        rd(5'h00, 8);
        check("cs_rsv", r, 32'hc2);
        wcs(8'hc3);
        rd(5'h00, 8);
        check("lsb_cs", r, 32'hc3);
        v = 24'($random(seed)) & 24'hff7f80;
        func_case(v);
        rd(5'h01, 24);
        check("lsb_func", r, {8'h0, v});
        wcs(8'hc0);
        for (int m = 0; m < 2; m++) begin
            wcs(m ? 8'hc6 : 8'hc4);
            v = 24'($random(seed)) & 24'hff7f80;
            func_case(v);
            wcs(8'hc0);
            rd(5'h01, 24);
            check("wide_func", r, {8'h0, v});
        end
        // a reset in mid-run must restore the defaults over a changed setup
        wcs(8'h43);
        sys_rst = 1'b1;
        host.tick(2);
        sys_rst = 1'b0;
        host.tick(1);
        check("mid_rst_cfg", 32'(port_cfg), 32'h18);
        check("mid_rst_func", 32'(func), 32'h0);
        finish_test();
    end

    // the scenarios need about 8000 cycles; this leaves ample margin
    initial begin
        repeat (40000) @(posedge clock);
        num_errors++;
        finish_test();
    end
endmodule
